// File: common/vtr_params.svh
// Offsets, field positions, reset values and counts for vector relocation
`ifndef VTR_PARAMS_SVH
`define VTR_PARAMS_SVH

// Register byte offsets on the APB
`define VTR_MCU_CTRL_OFS      12'h000
`define VTR_STATUS_OFS        12'h004

// Control register fields
`define VTR_UNLOCK_BIT        0
`define VTR_SELECT_BIT        1
`define VTR_MCU_CTRL_RST      8'h00

// Status register fields
`define VTR_ST_BLOCK_BIT      0
`define VTR_ST_OPEN_BIT       1
`define VTR_ST_POST_BIT       2
`define VTR_ST_STARTED_BIT    3
`define VTR_ST_CNT_LSB        4
`define VTR_ST_CNT_MSB        6
`define VTR_ST_FUSE_BIT       8
`define VTR_ST_BOOT_LSB       16
`define VTR_ST_BOOT_MSB       29

// Synchronised fuse vector layout
`define VTR_FZ_RST            0
`define VTR_FZ_SZ_LSB         1
`define VTR_FZ_SZ_MSB         2
`define VTR_FZ_APP_LOCK       3
`define VTR_FZ_BOOT_LOCK      4

// Unlock window length and start-up delay in clock cycles
`define VTR_UNLOCK_CYCLES     3'h4
`define VTR_START_CYCLES      2'h2

// Vector table layout, word addresses
`define VTR_APP_RESET_ADDR    14'h0000
`define VTR_VEC_SPACING       14'h0002
`define VTR_VEC_NUM_MIN       5'h02
`define VTR_VEC_NUM_MAX       5'h1D

// Flash size and boot section sizes in words
`define VTR_FLASH_WORDS       14'h2000
`define VTR_BOOT_WORDS_SZ0    14'h0800
`define VTR_BOOT_WORDS_SZ1    14'h0400
`define VTR_BOOT_WORDS_SZ2    14'h0200
`define VTR_BOOT_WORDS_SZ3    14'h0100

`endif

// File: common/vtr_pkg.sv
// Types shared by the vector relocation block
package vtr_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_OPEN = 2'h1,
    SEQ_POST = 2'h3
  } seq_state_t;

  typedef struct packed {
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [1:0]  start_cnt;
    logic        started;
    logic [13:0] reset_addr;
    logic        sel;
    seq_state_t  seq;
    logic [2:0]  unlock_cnt;
    logic        block;
    logic        take;
    logic [13:0] vec_addr;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } vtr_state_t;

endpackage

// File: design/boot_start_lookup.sv
// Boot section start address from the boot size fuses
`timescale 1ns/1ps
`include "vtr_params.svh"

module boot_start_lookup (
  input  wire logic [1:0]  boot_size_fuses_i,
  output logic      [13:0] boot_start_o
);

  logic [13:0] boot_words;

  always_comb begin
    case (boot_size_fuses_i)
      2'h0:    boot_words = `VTR_BOOT_WORDS_SZ0;
      2'h1:    boot_words = `VTR_BOOT_WORDS_SZ1;
      2'h2:    boot_words = `VTR_BOOT_WORDS_SZ2;
      default: boot_words = `VTR_BOOT_WORDS_SZ3;
    endcase
    // Boot section always sits at the top of flash
    boot_start_o = `VTR_FLASH_WORDS - boot_words;
  end

endmodule // boot_start_lookup

// File: design/vector_table_relocation.sv
// Vector table placement, unlock sequence and interrupt blocking
`timescale 1ns/1ps
`include "vtr_params.svh"

module vector_table_relocation (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Fuse and lock straps, asynchronous to mclk_i
  input  wire logic        boot_reset_fuse_i,
  input  wire logic [1:0]  boot_size_fuses_i,
  input  wire logic        app_side_boot_lock_i,
  input  wire logic        boot_side_boot_lock_i,
  // Core fetch and dispatch side
  input  wire logic [13:0] core_pc_i,
  input  wire logic        core_instr_done_i,
  input  wire logic        global_irq_en_i,
  input  wire logic        irq_pend_i,
  input  wire logic [4:0]  irq_num_i,
  output logic             irq_take_o,
  output logic      [13:0] irq_vec_addr_o,
  output logic             irq_block_o,
  output logic             vector_base_select_o,
  output logic      [13:0] reset_addr_o,
  output logic             core_boot_ready_o
);

  vtr_pkg::vtr_state_t state_ff;
  vtr_pkg::vtr_state_t nxt_state;

  logic [13:0] boot_start;
  logic [4:0]  fuse_pins;

  assign fuse_pins = {boot_side_boot_lock_i,
                      app_side_boot_lock_i,
                      boot_size_fuses_i,
                      boot_reset_fuse_i};

  boot_start_lookup u_boot_start (
    .boot_size_fuses_i (state_ff.sync2[`VTR_FZ_SZ_MSB:`VTR_FZ_SZ_LSB]),
    .boot_start_o      (boot_start)
  );

  // Bus decode helpers
  logic        bus_done;
  logic        bus_wr;
  logic        bus_hit_ctrl;
  logic        bus_hit_stat;
  logic [31:0] rd_word;
  // Control and masking helpers
  logic        wr_unlock;
  logic        wr_select;
  logic        in_boot;
  logic        lock_block;
  logic        num_ok;
  logic [13:0] vec_base;
  logic [13:0] vec_offs;

  always_comb begin
    nxt_state = state_ff;

    // Two-flop synchronisers on the straps
    nxt_state.sync1 = fuse_pins;
    nxt_state.sync2 = state_ff.sync1;

    // Reset address caught once the synchronised fuse is valid
    if (!state_ff.started) begin
      if (state_ff.start_cnt == `VTR_START_CYCLES) begin
        nxt_state.started = 1'b1;
        if (state_ff.sync2[`VTR_FZ_RST]) begin
          nxt_state.reset_addr = `VTR_APP_RESET_ADDR;
        end else begin
          nxt_state.reset_addr = boot_start;
        end
      end else begin
        nxt_state.start_cnt = state_ff.start_cnt + 2'h1;
      end
    end

    // APB: one wait state, completion when pready was raised
    bus_done     = psel_i && penable_i && state_ff.pready;
    bus_wr       = bus_done && pwrite_i;
    bus_hit_ctrl = (paddr_i == `VTR_MCU_CTRL_OFS);
    bus_hit_stat = (paddr_i == `VTR_STATUS_OFS);

    wr_unlock = bus_wr && bus_hit_ctrl &&
                pwdata_i[`VTR_UNLOCK_BIT];
    wr_select = bus_wr && bus_hit_ctrl &&
                !pwdata_i[`VTR_UNLOCK_BIT];

    // Unlock window and post-write hold
    case (state_ff.seq)
      vtr_pkg::SEQ_IDLE: begin
        if (wr_unlock) begin
          nxt_state.seq        = vtr_pkg::SEQ_OPEN;
          nxt_state.unlock_cnt = `VTR_UNLOCK_CYCLES;
        end
        // A plain select write here changes nothing
      end
      vtr_pkg::SEQ_OPEN: begin
        if (wr_unlock) begin
          // Rewriting unlock re-arms the window
          nxt_state.unlock_cnt = `VTR_UNLOCK_CYCLES;
        end else if (wr_select) begin
          nxt_state.sel        = pwdata_i[`VTR_SELECT_BIT];
          nxt_state.seq        = vtr_pkg::SEQ_POST;
          nxt_state.unlock_cnt = 3'h0;
        end else if (state_ff.unlock_cnt == 3'h1) begin
          nxt_state.seq        = vtr_pkg::SEQ_IDLE;
          nxt_state.unlock_cnt = 3'h0;
        end else begin
          nxt_state.unlock_cnt = state_ff.unlock_cnt - 3'h1;
        end
      end
      vtr_pkg::SEQ_POST: begin
        // Held until the instruction after the select write retires
        if (wr_unlock) begin
          nxt_state.seq        = vtr_pkg::SEQ_OPEN;
          nxt_state.unlock_cnt = `VTR_UNLOCK_CYCLES;
        end else if (core_instr_done_i) begin
          nxt_state.seq = vtr_pkg::SEQ_IDLE;
        end
      end
      default: begin
        nxt_state.seq        = vtr_pkg::SEQ_IDLE;
        nxt_state.unlock_cnt = 3'h0;
      end
    endcase

    // Boot lock masking follows the new placement at once
    in_boot    = (core_pc_i >= boot_start);
    lock_block = (nxt_state.sel && !in_boot &&
                  !state_ff.sync2[`VTR_FZ_APP_LOCK]) ||
                 (!nxt_state.sel && in_boot &&
                  !state_ff.sync2[`VTR_FZ_BOOT_LOCK]);

    // Only a gate on dispatch; the core's I-bit is never written
    nxt_state.block = (nxt_state.seq != vtr_pkg::SEQ_IDLE) ||
                      lock_block;

    // Vector address: base plus two words per vector number
    num_ok   = (irq_num_i >= `VTR_VEC_NUM_MIN) &&
               (irq_num_i <= `VTR_VEC_NUM_MAX);
    vec_base = nxt_state.sel ? boot_start : 14'h0000;
    vec_offs = {8'h00, irq_num_i - 5'h01, 1'b0};

    // One-cycle take pulse; the core drops its request afterwards
    nxt_state.take = irq_pend_i && global_irq_en_i && num_ok &&
                     state_ff.started && !nxt_state.block &&
                     !state_ff.take;
    if (nxt_state.take) begin
      nxt_state.vec_addr = vec_base + vec_offs;
    end

    // Read data assembled from current state
    rd_word = 32'h0000_0000;
    if (bus_hit_ctrl) begin
      rd_word[`VTR_SELECT_BIT] = state_ff.sel;
      rd_word[`VTR_UNLOCK_BIT] = (state_ff.seq == vtr_pkg::SEQ_OPEN);
    end else if (bus_hit_stat) begin
      rd_word[`VTR_ST_BLOCK_BIT]   = state_ff.block;
      rd_word[`VTR_ST_OPEN_BIT]    = (state_ff.seq == vtr_pkg::SEQ_OPEN);
      rd_word[`VTR_ST_POST_BIT]    = (state_ff.seq == vtr_pkg::SEQ_POST);
      rd_word[`VTR_ST_STARTED_BIT] = state_ff.started;
      rd_word[`VTR_ST_CNT_MSB:`VTR_ST_CNT_LSB] = state_ff.unlock_cnt;
      rd_word[`VTR_ST_FUSE_BIT]    = state_ff.sync2[`VTR_FZ_RST];
      rd_word[`VTR_ST_BOOT_MSB:`VTR_ST_BOOT_LSB] = boot_start;
    end

    nxt_state.pready  = psel_i && penable_i && !state_ff.pready;
    nxt_state.pslverr = nxt_state.pready && !bus_hit_ctrl && !bus_hit_stat;
    if (nxt_state.pready && !pwrite_i) begin
      nxt_state.prdata = rd_word;
    end else begin
      nxt_state.prdata = 32'h0000_0000;
    end
  end

  // Reset leaves the select at zero: vectors in application flash
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata_o             = state_ff.prdata;
  assign pready_o             = state_ff.pready;
  assign pslverr_o            = state_ff.pslverr;
  assign irq_take_o           = state_ff.take;
  assign irq_vec_addr_o       = state_ff.vec_addr;
  assign irq_block_o          = state_ff.block;
  assign vector_base_select_o = state_ff.sel;
  assign reset_addr_o         = state_ff.reset_addr;
  assign core_boot_ready_o    = state_ff.started;

endmodule // vector_table_relocation

// File: dv/core_model.sv
// Core side model: one pending request, periodic retire pulse
`timescale 1ns/1ps
module core_model (
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire logic       req_i,
  input  wire logic [4:0] num_i,
  input  wire logic       take_i,
  output logic            pend_o,
  output logic      [4:0] num_o,
  output logic            done_o
);
  logic [1:0] cnt_ff;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_o <= 1'b0;
      num_o  <= 5'h00;
      cnt_ff <= 2'h0;
      done_o <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      done_o <= cnt_ff == 2'h3;
      if (take_i) begin
        pend_o <= 1'b0;
        // Number is stale once released, so scramble it
        num_o  <= ~num_o;
      end else if (req_i) begin
        pend_o <= 1'b1;
        num_o  <= num_i;
      end
    end
  end
endmodule // core_model

// File: dv/test_vector_table_relocation.sv
// Directed bench for vector table relocation
`timescale 1ns/1ps
`include "vtr_params.svh"
module test_vector_table_relocation;
  logic        mclk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o;
  logic        pslverr_o, boot_reset_fuse_i, app_side_boot_lock_i, err;
  logic        boot_side_boot_lock_i, core_instr_done_i, global_irq_en_i;
  logic        irq_pend_i, irq_take_o, irq_block_o, vector_base_select_o;
  logic        core_boot_ready_o, req;
  logic [1:0]  boot_size_fuses_i;
  logic [4:0]  irq_num_i, rnum;
  logic [11:0] paddr_i;
  logic [13:0] core_pc_i, irq_vec_addr_o, reset_addr_o;
  logic [31:0] pwdata_i, prdata_o, rd;
  int          error_cnt, checks_done;
  localparam logic [11:0] CTL = `VTR_MCU_CTRL_OFS;
  vector_table_relocation i_vector_table_relocation (.*);
  core_model i_core_model (.mclk_i, .arst_n_i, .req_i(req), .num_i(rnum),
    .take_i(irq_take_o), .pend_o(irq_pend_i), .num_o(irq_num_i),
    .done_o(core_instr_done_i));
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic chk(input string s, input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic lim(input int k);
    if (k >= 40) begin
      chk("wait", 32'h0, 32'h1);
      conclude();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic k);
    int n;
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    lim(n);
    rd = prdata_o;
    err = pslverr_o;
    penable_i <= 1'b0;
    // Select stays up when the next setup follows at once
    if (!k) psel_i <= 1'b0;
  endtask
  task automatic irq(input logic [4:0] n, input logic [13:0] e);
    int k;
    @(posedge mclk_i);
    req  <= 1'b1;
    rnum <= n;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (irq_take_o !== 1'b1 && k < 40);
    lim(k);
    req <= 1'b0;
    chk("vec", 32'(irq_vec_addr_o), 32'(e));
  endtask
  task automatic rst(input logic f, input logic [1:0] s);
    int k;
    logic [13:0] e;
    arst_n_i <= 1'b0;
    boot_reset_fuse_i <= f;
    boot_size_fuses_i <= s;
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (core_boot_ready_o !== 1'b1 && k < 40);
    lim(k);
    e = f ? 14'h0000 : 14'h2000 - (14'h0800 >> s);
    chk("rst addr", 32'(reset_addr_o), 32'(e));
    $display("reset done");
  endtask
  task automatic t_vec();
    apb(1'b0, CTL, 32'h0, 1'b0);
    chk("ctl rst", rd, 32'h0);
    for (int i = 27; i <= 29; i++)
      irq(5'(i), 14'(2 * (i - 1)));
    apb(1'b1, CTL, 32'h2, 1'b0);
    @(posedge mclk_i);
    chk("sel", 32'(vector_base_select_o), 32'h0);
    apb(1'b0, 12'h008, 32'h0, 1'b0);
    chk("err", 32'(err), 32'h1);
    chk("err rd", rd, 32'h0);
    $display("vectors done");
  endtask
  task automatic t_unlock();
    int k;
    @(posedge mclk_i);
    apb(1'b1, CTL, 32'h1, 1'b0);
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (irq_block_o === 1'b1 && k < 40);
    lim(k);
    chk("blk len", 32'(k), 32'(`VTR_UNLOCK_CYCLES) + 32'h1);
    apb(1'b1, CTL, 32'h1, 1'b1);
    apb(1'b0, CTL, 32'h0, 1'b0);
    chk("unlock", rd, 32'h1);
    @(posedge mclk_i);
    apb(1'b0, CTL, 32'h0, 1'b0);
    chk("unlock clr", rd, 32'h0);
    $display("unlock done");
  endtask
  task automatic t_move(input logic s, input logic [13:0] e);
    @(posedge mclk_i);
    apb(1'b1, CTL, 32'h1, 1'b1);
    apb(1'b1, CTL, {30'h0, s, 1'b0}, 1'b0);
    @(posedge mclk_i);
    chk("sel", 32'(vector_base_select_o), 32'(s));
    irq(5'h1C, e);
    apb(1'b0, CTL, 32'h0, 1'b0);
    chk("ctl", rd, {30'h0, s, 1'b0});
    $display("move done");
  endtask
  task automatic pc_chk(input logic [13:0] pc, input logic e);
    core_pc_i <= pc;
    repeat (5) @(posedge mclk_i);
    chk("lock blk", 32'(irq_block_o), 32'(e));
  endtask
  task automatic t_lock();
    app_side_boot_lock_i <= 1'b0;
    pc_chk(14'h0100, 1'b1);
    pc_chk(14'h1900, 1'b0);
    app_side_boot_lock_i <= 1'b1;
    pc_chk(14'h0100, 1'b0);
    t_move(1'b0, 14'h0036);
    boot_side_boot_lock_i <= 1'b0;
    pc_chk(14'h1900, 1'b1);
    pc_chk(14'h0100, 1'b0);
    boot_side_boot_lock_i <= 1'b1;
    $display("lock done");
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, req, arst_n_i} = 5'h00;
    {app_side_boot_lock_i, boot_side_boot_lock_i, global_irq_en_i} = 3'h7;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    rnum = 5'h02;
    core_pc_i = 14'h0000;
    error_cnt = 0;
    checks_done = 0;
    rst(1'b1, 2'h0);
    t_vec();
    t_unlock();
    t_move(1'b1, 14'h2000 - 14'h0800 + 14'h0036);
    t_lock();
    rst(1'b0, 2'h1);
    irq(5'h02, 14'h0002);
    conclude();
  end
endmodule // test_vector_table_relocation

// File: dv/vtr_props.sv
// Port checker for the vector relocation block
`timescale 1ns/1ps
module vtr_props (
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        global_irq_en_i,
  input wire logic [4:0]  irq_num_i,
  input wire logic        irq_take_o,
  input wire logic [13:0] irq_vec_addr_o,
  input wire logic        irq_block_o,
  input wire logic        vector_base_select_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  wire logic wr = psel_i && penable_i && pready_o && pwrite_i;
  wire logic unl = wr && paddr_i == 12'h000 && pwdata_i[0];
  rdy_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  err_rdy_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  unlock_blk_a: assert property (unl |=> irq_block_o[*4])
    else $error("unlock did not block four cycles");
  sel_guard_a: assert property ($changed(vector_base_select_o) |-> $past(wr))
    else $error("select moved without a write");
  take_pulse_a: assert property (irq_take_o |=> !irq_take_o)
    else $error("take longer than one cycle");
  take_unblk_a: assert property (irq_take_o |-> !irq_block_o)
    else $error("take while blocked");
  take_ien_a: assert property (irq_take_o |-> $past(global_irq_en_i))
    else $error("take with interrupts disabled");
  vec_addr_a: assert property (irq_take_o && !vector_base_select_o |->
    irq_vec_addr_o == 14'({$past(irq_num_i) - 5'h01, 1'b0}))
    else $error("vector address off");
endmodule // vtr_props

bind vector_table_relocation vtr_props i_vtr_props (.*);
